// ### rtl/sector_map_dword.sv
// constants of the sector map table and the packer that builds one table dword
`timescale 1ns/1ps
package sector_map_pkg;
    // ****************************************************************
    // table placement (parameter-relative byte offsets)
    // ****************************************************************
    localparam logic [7:0]  OFS_FIRST         = 8'h6c;
    localparam logic [7:0]  OFS_C0_R2         = 8'h6c;
    localparam logic [7:0]  OFS_C2_HDR        = 8'h70;
    localparam logic [7:0]  OFS_C2_R0         = 8'h74;
    localparam logic [7:0]  OFS_LAST          = 8'h77;
    localparam int unsigned N_DWORDS          = 3;
    localparam logic [7:0]  MISS_DATA         = 8'hff;
    localparam logic [31:0] MISS_WORD         = 32'hffff_ffff;

    // ****************************************************************
    // region size encoding
    // ****************************************************************
    localparam int unsigned UNIT_BYTES        = 256;
    localparam int unsigned SECTOR_64K_BYTES  = 65536;
    localparam int unsigned SECTORS_64K       = 127;
    localparam logic [23:0] SIZE_64K_REGION   =
        24'((SECTORS_64K * SECTOR_64K_BYTES) / UNIT_BYTES - 1);
    localparam int unsigned SIZE_LSB          = 8;
    localparam int unsigned SIZE_MSB          = 31;

    // ****************************************************************
    // region descriptor low byte
    // ****************************************************************
    localparam logic [3:0]  REGION_RFU        = 4'hf;
    localparam int unsigned ERASE_T1_BIT      = 0;
    localparam int unsigned ERASE_T2_BIT      = 1;
    localparam int unsigned ERASE_T3_BIT      = 2;
    localparam int unsigned ERASE_T4_BIT      = 3;
    localparam logic        ERASE_NO          = 1'b0;
    localparam logic        ERASE_YES         = 1'b1;
    localparam logic [3:0]  ERASE_64K_REGION  =
        {ERASE_NO, ERASE_NO, ERASE_YES, ERASE_NO};

    // ****************************************************************
    // configuration header
    // ****************************************************************
    localparam logic [7:0]  HDR_RFU_HI        = 8'hff;
    localparam int unsigned HDR_RFU_HI_LSB    = 24;
    localparam int unsigned HDR_COUNT_LSB     = 16;
    localparam int unsigned HDR_CFGID_LSB     = 8;
    localparam logic [5:0]  HDR_RFU_LO        = 6'h3f;
    localparam int unsigned HDR_RFU_LO_LSB    = 2;
    localparam int unsigned HDR_DESC_BIT      = 1;
    localparam int unsigned HDR_END_BIT       = 0;
    localparam logic        HDR_IS_MAP        = 1'b1;
    localparam logic        HDR_NOT_LAST      = 1'b0;
    localparam logic [7:0]  C2_COUNT_M1       = 8'h02;
    localparam logic [7:0]  C2_CFG_ID         = 8'h02;

    // ****************************************************************
    // per-dword contents, index 0 = lowest offset
    // ****************************************************************
    localparam logic        DW_IS_HDR [N_DWORDS] = '{1'b0, 1'b1, 1'b0};
    localparam logic [23:0] DW_SIZE   [N_DWORDS] =
        '{SIZE_64K_REGION, 24'h00_0000, SIZE_64K_REGION};
    localparam logic [3:0]  DW_ERASE  [N_DWORDS] =
        '{ERASE_64K_REGION, 4'h0, ERASE_64K_REGION};

    // ****************************************************************
    // read state machine
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_ANSWER = 2'b10
    } rd_state_t;
endpackage : sector_map_pkg

module sector_map_dword
    import sector_map_pkg::*;
(
    // kind of dword
    input  wire logic        is_header,
    // header fields
    input  wire logic [7:0]  count_m1,
    input  wire logic [7:0]  cfg_id,
    input  wire logic        last_desc,
    // region fields
    input  wire logic [23:0] size_m1,
    input  wire logic [3:0]  erase_sup,
    // packed result
    output logic      [31:0] dword
);
    always_comb begin
        dword = 32'h0000_0000;
        if (is_header) begin
            dword[HDR_RFU_HI_LSB +: 8] = HDR_RFU_HI;
            dword[HDR_COUNT_LSB +: 8]  = count_m1;
            dword[HDR_CFGID_LSB +: 8]  = cfg_id;
            dword[HDR_RFU_LO_LSB +: 6] = HDR_RFU_LO;
            dword[HDR_DESC_BIT]        = HDR_IS_MAP;
            dword[HDR_END_BIT]         = last_desc;
        end else begin
            dword[SIZE_MSB:SIZE_LSB]   = size_m1;
            dword[7:4]                 = REGION_RFU;
            dword[3:0]                 = erase_sup;
        end
    end
endmodule : sector_map_dword

// ### rtl/sector_map_param_rom.sv
// read-only sector map parameter table slice with a one-cycle byte/dword read port
`timescale 1ns/1ps
module sector_map_param_rom
    import sector_map_pkg::*;
(
    // clock, enable and reset
    input  wire logic        clk,
    input  wire logic        ce,
    input  wire logic        sys_rst,
    // read request
    input  wire logic        rd_req,
    input  wire logic [7:0]  rd_addr,
    // read answer
    output logic             rd_valid,
    output logic             rd_hit,
    output logic      [7:0]  rd_data,
    output logic      [31:0] rd_word
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        rd_state_t   fsm;
        logic        valid;
        logic        hit;
        logic [7:0]  addr;
        logic [7:0]  data;
        logic [31:0] word;
    } rom_state_t;

    rom_state_t state;
    rom_state_t next_state;

    // ****************************************************************
    // table contents
    // ****************************************************************
    logic [31:0] dwords [N_DWORDS];

    // one packer per dword; the contents are fixed by constants only
    genvar gi;
    generate
        for (gi = 0; gi < N_DWORDS; gi++) begin : g_dw
            sector_map_dword u_dw (
                .is_header (DW_IS_HDR[gi]),
                .count_m1  (C2_COUNT_M1),
                .cfg_id    (C2_CFG_ID),
                .last_desc (HDR_NOT_LAST),
                .size_m1   (DW_SIZE[gi]),
                .erase_sup (DW_ERASE[gi]),
                .dword     (dwords[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // address decode
    // ****************************************************************
    logic [7:0] rel_off;
    logic       in_table;
    logic [1:0] dw_idx;
    logic [1:0] byte_sel;
    logic [31:0] sel_word;
    logic [7:0]  sel_byte;

    always_comb begin
        rel_off  = 8'(rd_addr - OFS_FIRST);
        in_table = (rd_addr >= OFS_FIRST) && (rd_addr <= OFS_LAST);
        dw_idx   = rel_off[3:2];
        byte_sel = rel_off[1:0];
        sel_word = MISS_WORD;
        if (in_table) begin
            case (dw_idx)
                2'h0:    sel_word = dwords[0];
                2'h1:    sel_word = dwords[1];
                2'h2:    sel_word = dwords[2];
                default: sel_word = MISS_WORD;
            endcase
        end
        // dwords go out least significant byte first
        sel_byte = sel_word[8*byte_sel +: 8];
    end

    // ****************************************************************
    // read sequencer
    // ****************************************************************
    always_comb begin
        next_state       = state;
        next_state.valid = 1'b0;
        case (state.fsm)
            ST_IDLE: begin
                if (rd_req) begin
                    next_state.fsm = ST_ANSWER;
                end
            end
            ST_ANSWER: begin
                if (!rd_req) begin
                    next_state.fsm = ST_IDLE;
                end
            end
            default: begin
                next_state.fsm = ST_IDLE;
            end
        endcase
        // back-to-back requests are answered every cycle
        if (rd_req) begin
            next_state.valid = 1'b1;
            next_state.hit   = in_table;
            next_state.addr  = rd_addr;
            next_state.data  = sel_byte;
            next_state.word  = sel_word;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state.fsm   <= ST_IDLE;
            state.valid <= 1'b0;
            state.hit   <= 1'b0;
            state.addr  <= 8'h00;
            state.data  <= 8'h00;
            state.word  <= 32'h0000_0000;
        end else if (ce) begin
            state <= next_state;
        end
    end

    assign rd_valid = state.valid;
    assign rd_hit   = state.hit;
    assign rd_data  = state.data;
    assign rd_word  = state.word;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic take;
    assign take = ce && rd_req;

    property p_size_field;
        take && rd_addr == OFS_C0_R2 |=> rd_word[SIZE_MSB:SIZE_LSB] == 24'h007eff;
    endproperty
    a_size_field: assert property (p_size_field) else $error("size field wrong");

    property p_size_bytes;
        take && rd_addr == 8'h6d |=> rd_data == 8'hff && rd_word == 32'h007e_fff2;
    endproperty
    a_size_bytes: assert property (p_size_bytes) else $error("size byte wrong");
    property p_size_top;
        take && rd_addr == 8'h76 |=> rd_data == 8'h7e && rd_hit;
    endproperty
    a_size_top: assert property (p_size_top) else $error("size top byte wrong");

    property p_erase_t2;
        take && (rd_addr == OFS_C0_R2 || rd_addr == OFS_C2_R0)
            |=> rd_data[ERASE_T2_BIT] == 1'b1;
    endproperty
    a_erase_t2: assert property (p_erase_t2) else $error("erase type 2 not set");

    property p_erase_t3;
        take && rd_addr == OFS_C0_R2 |=> rd_data[ERASE_T3_BIT] == 1'b0;
    endproperty
    a_erase_t3: assert property (p_erase_t3) else $error("erase type 3 set");

    property p_erase_t1;
        take && rd_addr == OFS_C2_R0 |=> !rd_data[ERASE_T1_BIT] && rd_data[7:4] == 4'hf;
    endproperty
    a_erase_t1: assert property (p_erase_t1) else $error("erase type 1 set");

    property p_erase_t4;
        rd_valid && rd_hit && (state.addr == OFS_C0_R2 || state.addr == OFS_C2_R0)
            |-> rd_data[ERASE_T4_BIT] == 1'b0;
    endproperty
    a_erase_t4: assert property (p_erase_t4) else $error("erase type 4 set");

    property p_hdr_count;
        take && rd_addr == 8'h72 |=> rd_data == 8'h02;
    endproperty
    a_hdr_count: assert property (p_hdr_count) else $error("region count wrong");

    property p_hdr_cfgid;
        take && rd_addr == 8'h71 |=> rd_data == 8'h02;
    endproperty
    a_hdr_cfgid: assert property (p_hdr_cfgid) else $error("config id wrong");

    property p_hdr_desc;
        take && rd_addr == OFS_C2_HDR |=> rd_data[HDR_DESC_BIT] && !rd_data[HDR_END_BIT];
    endproperty
    a_hdr_desc: assert property (p_hdr_desc) else $error("header low bits wrong");

    property p_hdr_word;
        take && rd_addr == OFS_C2_HDR |=> rd_word == 32'hff02_02fe;
    endproperty
    a_hdr_word: assert property (p_hdr_word) else $error("header dword wrong");

    property p_hdr_rfu;
        take && rd_addr == 8'h73 |=> rd_data == 8'hff;
    endproperty
    a_hdr_rfu: assert property (p_hdr_rfu) else $error("reserved bits not ones");

    property p_support_match;
        take && rd_addr == OFS_C2_R0 |=> rd_data[3:0] == 4'h2 && rd_word == 32'h007e_fff2;
    endproperty
    a_support_match: assert property (p_support_match) else $error("erase bits wrong");

    property p_repeat_same;
        take && rd_addr inside {[OFS_FIRST:OFS_LAST]}
            ##1 take && rd_addr == state.addr |=> rd_data == $past(rd_data);
    endproperty
    a_repeat_same: assert property (p_repeat_same) else $error("repeat read differs");

    property p_answer_timing;
        take |=> rd_valid && rd_hit == ($past(rd_addr) inside {[OFS_FIRST:OFS_LAST]});
    endproperty
    a_answer_timing: assert property (p_answer_timing) else $error("answer late or hit wrong");

    property p_no_spurious;
        ce && !rd_req |=> !rd_valid;
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("answer without request");

    property p_miss;
        take && !(rd_addr inside {[OFS_FIRST:OFS_LAST]}) |=> rd_data == MISS_DATA && !rd_hit;
    endproperty
    a_miss: assert property (p_miss) else $error("miss answer wrong");

    c_read_hdr:   cover property (take && rd_addr == OFS_C2_HDR ##1 rd_valid);
    c_read_reg:   cover property (take && rd_addr == OFS_C0_R2 ##1 rd_valid && rd_hit);
    c_back2back:  cover property (take [*3]);
    c_miss:       cover property (rd_valid && !rd_hit);
    c_stall:      cover property (rd_valid && !ce ##1 rd_valid);

endmodule : sector_map_param_rom

// ### tb/host_reader.sv
// behavioural host that issues parameter table reads, one slot per clock
`timescale 1ns/1ps
module host_reader (
    // clock
    input  wire logic       clk,
    // request to the table
    output logic            rd_req,
    output logic      [7:0] rd_addr
);
    initial begin
        rd_req  = 1'b0;
        rd_addr = 8'h00;
    end

    // ****************************************************************
    // one request slot
    // ****************************************************************
    // an idle slot shows the inverse of the last offset, so a table that
    // samples the offset without a request gives itself away
    task automatic slot(input logic en, input logic [7:0] addr);
        @(negedge clk);
        rd_req  <= en;
        rd_addr <= en ? addr : ~rd_addr;
    endtask : slot
endmodule : host_reader

// ### tb/sector_map_param_rom_test.sv
// self-checking bench for the sector map parameter table slice
`timescale 1ns/1ps
module sector_map_param_rom_test;
    localparam int unsigned TIMEOUT_CYCLES = 2000;

    logic        clk;
    logic        ce;
    logic        sys_rst;
    logic        rd_req;
    logic [7:0]  rd_addr;
    logic        rd_valid;
    logic        rd_hit;
    logic [7:0]  rd_data;
    logic [31:0] rd_word;
    int          mismatches;
    int          tests_run;

    sector_map_param_rom dut_u (
        .clk(clk), .ce(ce), .sys_rst(sys_rst), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_valid(rd_valid), .rd_hit(rd_hit), .rd_data(rd_data), .rd_word(rd_word)
    );
    host_reader host_u (.clk(clk), .rd_req(rd_req), .rd_addr(rd_addr));

    // ****************************************************************
    // checking helpers
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    // dword images built straight from the field layout
    function automatic logic [31:0] exp_word(input logic [7:0] addr);
        if ((addr >= 8'h6c && addr <= 8'h6f) || (addr >= 8'h74 && addr <= 8'h77))
            return {24'((127 * 65536) / 256 - 1), 4'hf, 4'b0010};
        if (addr >= 8'h70 && addr <= 8'h73)
            return {8'hff, 8'h02, 8'h02, 6'h3f, 1'b1, 1'b0};
        return 32'hffff_ffff;
    endfunction : exp_word

    task automatic region_fields;
        chk("size_m1", rd_word[31:8], 32'h0000_7eff);
        chk("erase_t2", rd_word[1], 1'b1);
        chk("erase_t3", rd_word[2], 1'b0);
        chk("erase_t1", rd_word[0], 1'b0);
        chk("erase_t4", rd_word[3], 1'b0);
    endtask : region_fields

    task automatic header_fields;
        chk("count_m1", rd_word[23:16], 8'h02);
        chk("cfg_id", rd_word[15:8], 8'h02);
        chk("map_desc", rd_word[1], 1'b1);
        chk("end_desc", rd_word[0], 1'b0);
        chk("rfu_hi", rd_word[31:24], 8'hff);
        chk("rfu_lo", rd_word[7:2], 6'h3f);
    endtask : header_fields

    task automatic check_answer(input logic [7:0] addr);
        logic [31:0] w;
        logic        hit;
        w   = exp_word(addr);
        hit = (addr >= 8'h6c && addr <= 8'h77);
        chk("rd_valid", rd_valid, 1'b1);
        chk("rd_hit", rd_hit, hit);
        chk("rd_data", rd_data, hit ? w[8 * addr[1:0] +: 8] : 8'hff);
        chk("rd_word", rd_word, w);
        if (addr == 8'h6c || addr == 8'h74)
            region_fields();
        if (addr == 8'h70)
            header_fields();
    endtask : check_answer

    // back-to-back reads, each answer judged in the cycle after its edge
    task automatic run_list(input logic [7:0] addrs[$]);
        for (int i = 0; i <= addrs.size(); i++) begin
            host_u.slot(i < addrs.size(), i < addrs.size() ? addrs[i] : 8'h00);
            if (i > 0)
                check_answer(addrs[i - 1]);
        end
        host_u.slot(1'b0, 8'h00);
        chk("valid_drop", rd_valid, 1'b0);
        chk("word_held", rd_word, exp_word(addrs[addrs.size() - 1]));
    endtask : run_list

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic sc_reset_values;
        chk("rst_valid", rd_valid, 1'b0);
        chk("rst_hit", rd_hit, 1'b0);
        chk("rst_data", rd_data, 8'h00);
        chk("rst_word", rd_word, 32'h0);
    endtask : sc_reset_values

    task automatic sc_whole_table;
        logic [7:0] q[$];
        for (int a = 8'h6c; a <= 8'h77; a++)
            q.push_back(8'(a));
        run_list(q);
    endtask : sc_whole_table

    task automatic sc_misses;
        run_list('{8'h6b, 8'h78, 8'h00, 8'hff, 8'h80, 8'h6f, 8'h6f});
    endtask : sc_misses

    // enable drops while an answer stands: the answer must hold until enable returns
    task automatic sc_freeze;
        host_u.slot(1'b1, 8'h70);
        host_u.slot(1'b0, 8'h00);
        ce <= 1'b0;
        check_answer(8'h70);
        repeat (3) begin
            @(negedge clk);
            chk("frozen_valid", rd_valid, 1'b1);
            chk("frozen_word", rd_word, exp_word(8'h70));
        end
        ce <= 1'b1;
        @(negedge clk);
        chk("valid_drop", rd_valid, 1'b0);
        chk("word_held", rd_word, exp_word(8'h70));
    endtask : sc_freeze

    // a second reset in mid-run must not disturb the table contents
    task automatic sc_rereset;
        logic [31:0] first;
        run_list('{8'h74});
        first = rd_word;
        sys_rst <= 1'b1;
        repeat (2) @(negedge clk);
        sc_reset_values();
        sys_rst <= 1'b0;
        run_list('{8'h74, 8'h70, 8'h74});
        chk("repeat_word", rd_word, first);
    endtask : sc_rereset

    // ****************************************************************
    // clock, reset, sequence and watchdog
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        mismatches = 0;
        tests_run  = 0;
        ce         = 1'b1;
        sys_rst    = 1'b1;
        repeat (20) @(negedge clk);
        sc_reset_values();
        sys_rst <= 1'b0;
        sc_whole_table();
        sc_misses();
        sc_freeze();
        sc_rereset();
        end_of_test();
    end

    initial begin
        repeat (TIMEOUT_CYCLES) @(posedge clk);
        mismatches++;
        end_of_test();
    end
endmodule : sector_map_param_rom_test
